//--- src/pmc_pkg.sv
// Package of modes, timing constants and state carriers for the power mode controller
package pmc_pkg;

   // Number of power-controllable subsystems and index of the CPU enable
   localparam int NUM_SUBSYS = 8;
   localparam int CPU_IDX = 0;

   // Global mode codes shown on mode_o
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_ALT = 2'h1;
   localparam logic [1:0] MODE_SLEEP = 2'h2;
   localparam logic [1:0] MODE_HIBERNATE = 2'h3;

   // Clock rate and resume times
   localparam int CLK_PERIOD_NS = 50;
   localparam int SLEEP_RESUME_US = 15;
   localparam int HIB_RESUME_US = 100;
   localparam int NS_PER_US = 1000;
   // Least time, rounded up to whole cycles
   localparam int SLEEP_RESUME_CYC =
      (SLEEP_RESUME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Longest time, rounded down
   localparam int HIB_RESUME_CYC = (HIB_RESUME_US * NS_PER_US) / CLK_PERIOD_NS;
   localparam int CNT_W = 12;

   // Reset values and the counter step
   localparam logic CORE_REG_RESET = 1'b1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

   typedef enum logic [2:0] {
      PMC_ST_ACTIVE,
      PMC_ST_ALT,
      PMC_ST_SLEEP,
      PMC_ST_HIB,
      PMC_ST_RESUME
   } pmc_state_t;

   // Wakeup sources other than the hibernate pin grouped together
   typedef struct packed {
      logic irq;
      logic reset_evt;
      logic sleep_src;
   } pmc_wake_t;

   // Regulator enables
   typedef struct packed {
      logic core_dig;
      logic core_ana;
      logic sleep_reg;
      logic hib_reg;
   } pmc_reg_t;

   // Whole state of the controller
   typedef struct packed {
      pmc_state_t state;
      logic [CNT_W-1:0] cnt;
      logic cpu_ovr;
      logic cpu_prev;
      logic core_reg_en;
      logic pin_s1;
      logic pin_s2;
      logic [1:0] mode;
      logic [NUM_SUBSYS-1:0] clk_en;
      logic [NUM_SUBSYS-1:0] bias_en;
      logic sleep_timer_run;
      logic all_clk_stop;
      logic retain;
      pmc_reg_t regs;
   } pmc_st_t;

endpackage

//--- src/pmc_ctrl.sv
// Global power mode sequencer with template gating and wakeup handling
//
// Function
// - Four global modes exist: active, alternate active, sleep and hibernate.
// - In active mode each subsystem follows its own bit of the active template, changeable anytime.
// - A disabled subsystem has its digital clock gated and its analog bias switched off.
// - The CPU may turn itself off by its template bit and is turned back on at the next wakeup.
// - Any wakeup sets the mode to active and enables the CPU whatever its template bit says.
// - After reset the mode is active.
// - Sleep disables almost everything regardless of templates, keeping only the sleep timer running and registers retained.
// - Hibernate stops all clocks, keeps registers and SRAM, and wakes only on an I/O pin event.
// - Hibernate turns off every internal regulator except the hibernate regulator.
// - Leaving sleep waits about 15 us for regulators to settle before entering active.
// - Core regulators are on after power-up and software may turn them off for external supply.
// - Enabled interrupts and reset events both count as wakeups and restore active mode from any mode but hibernate.
`timescale 1ns/10ps

module pmc_ctrl #(
   parameter int NUM_SUBSYS = pmc_pkg::NUM_SUBSYS,
   parameter int CPU_IDX = pmc_pkg::CPU_IDX,
   parameter int SLEEP_RESUME_CYC = pmc_pkg::SLEEP_RESUME_CYC,
   parameter int HIB_RESUME_CYC = pmc_pkg::HIB_RESUME_CYC
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic [NUM_SUBSYS-1:0] active_tmpl_i,
   input wire logic [NUM_SUBSYS-1:0] alt_tmpl_i,
   input wire logic mode_req_valid_i,
   input wire logic [1:0] mode_req_i,
   input wire pmc_pkg::pmc_wake_t wake_i,
   input wire logic pin_wake_i,
   input wire logic core_reg_off_i,
   output logic [1:0] mode_o,
   output logic [NUM_SUBSYS-1:0] clk_en_o,
   output logic [NUM_SUBSYS-1:0] bias_en_o,
   output logic sleep_timer_run_o,
   output logic all_clk_stop_o,
   output logic retain_o,
   output pmc_pkg::pmc_reg_t regs_o
);

   ////////////////////////////////////////////////////////////////////////////
   // State registers

   pmc_pkg::pmc_st_t st;
   pmc_pkg::pmc_st_t next_st;

   // Counts cut to the counter width on purpose; both defaults fit
   localparam logic [pmc_pkg::CNT_W-1:0] SLEEP_CNT = SLEEP_RESUME_CYC[pmc_pkg::CNT_W-1:0];
   localparam logic [pmc_pkg::CNT_W-1:0] HIB_CNT = HIB_RESUME_CYC[pmc_pkg::CNT_W-1:0];

   // Subsystem enable pattern for a mode, with CPU forced on by the override
   function automatic logic [NUM_SUBSYS-1:0] tmpl_sel(
      input logic [NUM_SUBSYS-1:0] tmpl,
      input logic ovr
   );
      logic [NUM_SUBSYS-1:0] r;
      r = tmpl;
      r[CPU_IDX] = tmpl[CPU_IDX] | ovr;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   // Wakeup arbitration sits ahead of software requests so a wake never gets lost
   always_comb begin
      logic any_wake;
      logic cpu_fall;
      logic [NUM_SUBSYS-1:0] en;
      any_wake = 1'b0;
      cpu_fall = 1'b0;
      en = '0;
      next_st = st;

      // Pin wake is asynchronous: two flops before use
      next_st.pin_s1 = pin_wake_i;
      next_st.pin_s2 = st.pin_s1;

      any_wake = wake_i.irq | wake_i.reset_evt;

      // Core regulators stay on until software asks otherwise
      if (core_reg_off_i) begin
         next_st.core_reg_en = 1'b0;
      end else begin
         next_st.core_reg_en = 1'b1;
      end

      // CPU override clears when the CPU turns itself off again; a wake wins
      next_st.cpu_prev = active_tmpl_i[CPU_IDX];
      cpu_fall = st.cpu_prev & ~active_tmpl_i[CPU_IDX];
      if (cpu_fall) begin
         next_st.cpu_ovr = 1'b0;
      end

      case (st.state)
         pmc_pkg::PMC_ST_ACTIVE, pmc_pkg::PMC_ST_ALT: begin
            if (any_wake) begin
               next_st.state = pmc_pkg::PMC_ST_ACTIVE;
               next_st.cpu_ovr = 1'b1;
            end else if (mode_req_valid_i) begin
               // Low power modes are entered only on request
               if (mode_req_i == pmc_pkg::MODE_ALT) begin
                  next_st.state = pmc_pkg::PMC_ST_ALT;
               end else if (mode_req_i == pmc_pkg::MODE_SLEEP) begin
                  next_st.state = pmc_pkg::PMC_ST_SLEEP;
               end else if (mode_req_i == pmc_pkg::MODE_HIBERNATE) begin
                  next_st.state = pmc_pkg::PMC_ST_HIB;
               end else begin
                  next_st.state = pmc_pkg::PMC_ST_ACTIVE;
               end
            end
         end
         pmc_pkg::PMC_ST_SLEEP: begin
            // Sleep-capable sources also wake from sleep
            if (any_wake | wake_i.sleep_src) begin
               next_st.state = pmc_pkg::PMC_ST_RESUME;
               next_st.cnt = SLEEP_CNT;
               next_st.cpu_ovr = 1'b1;
            end
         end
         pmc_pkg::PMC_ST_HIB: begin
            // Only the synchronised pin event is heard here
            if (st.pin_s2) begin
               next_st.state = pmc_pkg::PMC_ST_RESUME;
               next_st.cnt = HIB_CNT;
               next_st.cpu_ovr = 1'b1;
            end
         end
         pmc_pkg::PMC_ST_RESUME: begin
            // Settling wait; requests and further wakes are moot here
            if (st.cnt <= pmc_pkg::CNT_ONE) begin
               next_st.cnt = pmc_pkg::CNT_ZERO;
               next_st.state = pmc_pkg::PMC_ST_ACTIVE;
            end else begin
               next_st.cnt = st.cnt - pmc_pkg::CNT_ONE;
            end
         end
         default: begin
            next_st.state = pmc_pkg::PMC_ST_ACTIVE;
         end
      endcase

      ////////////////////////////////////////////////////////////////////////
      // Outputs follow the next state so they change with the mode itself

      next_st.sleep_timer_run = 1'b0;
      next_st.all_clk_stop = 1'b0;
      next_st.retain = 1'b0;
      next_st.regs.core_dig = next_st.core_reg_en;
      next_st.regs.core_ana = next_st.core_reg_en;
      next_st.regs.sleep_reg = 1'b0;
      next_st.regs.hib_reg = 1'b1;
      case (next_st.state)
         pmc_pkg::PMC_ST_ACTIVE: begin
            next_st.mode = pmc_pkg::MODE_ACTIVE;
            en = tmpl_sel(active_tmpl_i, next_st.cpu_ovr);
         end
         pmc_pkg::PMC_ST_ALT: begin
            // Alternate template is trusted to be the leaner one
            next_st.mode = pmc_pkg::MODE_ALT;
            en = tmpl_sel(alt_tmpl_i, next_st.cpu_ovr);
         end
         pmc_pkg::PMC_ST_HIB: begin
            next_st.mode = pmc_pkg::MODE_HIBERNATE;
            next_st.all_clk_stop = 1'b1;
            next_st.retain = 1'b1;
            next_st.regs.core_dig = 1'b0;
            next_st.regs.core_ana = 1'b0;
         end
         default: begin
            // Sleep and its resume wait: templates ignored
            next_st.mode = pmc_pkg::MODE_SLEEP;
            next_st.sleep_timer_run = 1'b1;
            next_st.retain = 1'b1;
            next_st.regs.sleep_reg = 1'b1;
         end
      endcase
      next_st.clk_en = en;
      next_st.bias_en = en;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register stage, frozen while the clock enable is low

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st.state <= pmc_pkg::PMC_ST_ACTIVE;
         st.cnt <= pmc_pkg::CNT_ZERO;
         st.cpu_ovr <= 1'b1;
         st.cpu_prev <= 1'b0;
         st.core_reg_en <= pmc_pkg::CORE_REG_RESET;
         st.pin_s1 <= 1'b0;
         st.pin_s2 <= 1'b0;
         st.mode <= pmc_pkg::MODE_ACTIVE;
         st.clk_en <= '0;
         st.bias_en <= '0;
         st.sleep_timer_run <= 1'b0;
         st.all_clk_stop <= 1'b0;
         st.retain <= 1'b0;
         st.regs.core_dig <= pmc_pkg::CORE_REG_RESET;
         st.regs.core_ana <= pmc_pkg::CORE_REG_RESET;
         st.regs.sleep_reg <= 1'b0;
         st.regs.hib_reg <= 1'b1;
      end else if (clk_en_i) begin
         st <= next_st;
      end
   end

   // Ports straight from the state flops
   assign mode_o = st.mode;
   assign clk_en_o = st.clk_en;
   assign bias_en_o = st.bias_en;
   assign sleep_timer_run_o = st.sleep_timer_run;
   assign all_clk_stop_o = st.all_clk_stop;
   assign retain_o = st.retain;
   assign regs_o = st.regs;

endmodule // pmc_ctrl

//--- verif/pmc_ctrl_chk.sv
// Checker of mode sequencing rules for the power mode controller
`timescale 1ns/10ps
module pmc_ctrl_chk #(
   parameter int NUM_SUBSYS = pmc_pkg::NUM_SUBSYS,
   parameter int CPU_IDX = pmc_pkg::CPU_IDX,
   parameter int SLEEP_RESUME_CYC = pmc_pkg::SLEEP_RESUME_CYC
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic [NUM_SUBSYS-1:0] active_tmpl_i,
   input wire logic mode_req_valid_i,
   input wire logic [1:0] mode_req_i,
   input wire pmc_pkg::pmc_wake_t wake_i,
   input wire logic pin_wake_i,
   input wire logic core_reg_off_i,
   input wire logic [1:0] mode_o,
   input wire logic [NUM_SUBSYS-1:0] clk_en_o,
   input wire logic [NUM_SUBSYS-1:0] bias_en_o,
   input wire logic retain_o,
   input wire logic all_clk_stop_o,
   input wire pmc_pkg::pmc_reg_t regs_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////////////////////////////////////
   // Gated clock and bias always move together
   property p_bias; bias_en_o == clk_en_o; endproperty
   a_bias: assert property (p_bias) else $error("bias differs from clock");
   property p_sleep; mode_o == pmc_pkg::MODE_SLEEP |-> !(|clk_en_o) && retain_o; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep left a subsystem on");
   property p_hib;
      mode_o == pmc_pkg::MODE_HIBERNATE |-> all_clk_stop_o && retain_o && regs_o == 4'h1;
   endproperty
   a_hib: assert property (p_hib) else $error("hibernate outputs wrong");
   // Only a synchronised pin event may end hibernate
   property p_hib_pin;
      (!pin_wake_i)[*3] ##0 mode_o == pmc_pkg::MODE_HIBERNATE |=> mode_o == pmc_pkg::MODE_HIBERNATE;
   endproperty
   a_hib_pin: assert property (p_hib_pin) else $error("hibernate left without pin");
   property p_wake;
      clk_en_i && (wake_i.irq || wake_i.reset_evt) && mode_o inside {2'h0, 2'h1}
         |=> mode_o == pmc_pkg::MODE_ACTIVE && clk_en_o[CPU_IDX];
   endproperty
   a_wake: assert property (p_wake) else $error("wake did not restore active");
   property p_req;
      clk_en_i && mode_req_valid_i && mode_o inside {2'h0, 2'h1} && !wake_i.irq
         && !wake_i.reset_evt |=> mode_o == $past(mode_req_i);
   endproperty
   a_req: assert property (p_req) else $error("mode request not taken");
   // Resume wait keeps the sleep code for the whole settle time
   property p_resume;
      mode_o == pmc_pkg::MODE_ACTIVE && $past(mode_o) == pmc_pkg::MODE_SLEEP
         |-> $past(mode_o, SLEEP_RESUME_CYC) == pmc_pkg::MODE_SLEEP;
   endproperty
   a_resume: assert property (p_resume) else $error("resume wait too short");
   property p_tmpl;
      mode_o == 2'h0 && $past(mode_o) == 2'h0 && $past(clk_en_i) && $past(reset_n_i)
         |-> clk_en_o[NUM_SUBSYS-1:1] == $past(active_tmpl_i[NUM_SUBSYS-1:1]);
   endproperty
   a_tmpl: assert property (p_tmpl) else $error("active template not followed");
   property p_core;
      mode_o == 2'h0 && $past(mode_o) == 2'h0 && $past(clk_en_i) && $past(reset_n_i)
         |-> regs_o.core_dig == !$past(core_reg_off_i) && regs_o.core_ana == regs_o.core_dig;
   endproperty
   a_core: assert property (p_core) else $error("core regulator enable wrong");
   c_alt: cover property (mode_o == pmc_pkg::MODE_ALT);
   c_sleep: cover property (mode_o == pmc_pkg::MODE_SLEEP);
   c_hib: cover property (mode_o == pmc_pkg::MODE_HIBERNATE);
endmodule // pmc_ctrl_chk
bind pmc_ctrl pmc_ctrl_chk #(.NUM_SUBSYS(NUM_SUBSYS), .CPU_IDX(CPU_IDX),
   .SLEEP_RESUME_CYC(SLEEP_RESUME_CYC)) pmc_ctrl_chk_inst (.clk_i, .reset_n_i, .clk_en_i,
   .active_tmpl_i, .mode_req_valid_i, .mode_req_i, .wake_i, .pin_wake_i, .core_reg_off_i,
   .mode_o, .clk_en_o, .bias_en_o, .retain_o, .all_clk_stop_o, .regs_o);

//--- verif/test_pmc_ctrl.sv
// Self-checking bench for the power mode controller
`timescale 1ns/10ps
module test_pmc_ctrl;
   // Short resume waits keep the run brief
   localparam int SR = 4;
   localparam int HR = 6;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic clk_en_i = 1'b1;
   logic [7:0] active_tmpl_i = 8'h00;
   logic [7:0] alt_tmpl_i = 8'h30; // Fewer subsystems than the active pattern
   logic mode_req_valid_i = 1'b0;
   logic [1:0] mode_req_i = 2'h0;
   pmc_pkg::pmc_wake_t wake_i = 3'h0;
   logic pin_wake_i = 1'b0;
   logic core_reg_off_i = 1'b0;
   logic [1:0] mode_o;
   logic [7:0] clk_en_o;
   logic [7:0] bias_en_o;
   logic sleep_timer_run_o;
   logic all_clk_stop_o;
   logic retain_o;
   pmc_pkg::pmc_reg_t regs_o;
   int failures = 0;
   int total_checks = 0;
   int n;
   pmc_ctrl #(.SLEEP_RESUME_CYC(SR), .HIB_RESUME_CYC(HR)) pmc_ctrl_inst (.clk_i, .reset_n_i,
      .clk_en_i, .active_tmpl_i, .alt_tmpl_i, .mode_req_valid_i, .mode_req_i, .wake_i,
      .pin_wake_i, .core_reg_off_i, .mode_o, .clk_en_o, .bias_en_o, .sleep_timer_run_o,
      .all_clk_stop_o, .retain_o, .regs_o);
   always #25 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Inputs move on the falling edge, clear of the sampling edge
   task automatic step(input int k);
      repeat (k) @(negedge clk_i);
   endtask
   // Low power modes are only ever entered through this request
   task automatic req(input logic [1:0] m);
      mode_req_i = m;
      mode_req_valid_i = 1'b1;
      step(1);
      mode_req_valid_i = 1'b0;
   endtask
   task automatic wake(input logic [2:0] w);
      wake_i = w;
      step(1);
      wake_i = 3'h0;
   endtask
   // Bounded wait; a hang ends the run as a failure
   task automatic wait_active;
      n = 0;
      while (mode_o !== pmc_pkg::MODE_ACTIVE && n < 40) begin
         step(1);
         n++;
      end
      if (n >= 40) begin
         failures++;
         close_out;
      end
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_boot;
      step(1);
      chk("mode", 8'h00, {6'h00, mode_o});
      chk("clk_en", 8'h01, clk_en_o);
      chk("regs", 8'h0d, {4'h0, regs_o});
      $display("test boot done");
   endtask
   task automatic t_active;
      active_tmpl_i = 8'ha6;
      step(1);
      chk("clk_en", 8'ha7, clk_en_o);
      chk("bias_en", 8'ha7, bias_en_o);
      active_tmpl_i = 8'h5b;
      step(1);
      active_tmpl_i = 8'h5a;
      step(1);
      chk("cpu off", 8'h5a, clk_en_o);
      wake(3'h4);
      chk("cpu back", 8'h5b, clk_en_o);
      $display("test active done");
   endtask
   task automatic t_alt;
      clk_en_i = 1'b0;
      req(2'h1);
      clk_en_i = 1'b1;
      chk("frozen", 8'h00, {6'h00, mode_o});
      // Let an edge pass so the request strobe is not raised where it was just lowered
      step(1);
      wake_i = 3'h4;
      req(2'h1);
      wake_i = 3'h0;
      chk("req with irq", 8'h00, {6'h00, mode_o});
      step(1);
      req(2'h1);
      chk("alt", 8'h01, {6'h00, mode_o});
      chk("alt clk", 8'h31, clk_en_o);
      wake(3'h2);
      chk("reset wake", 8'h00, {6'h00, mode_o});
      $display("test alt done");
   endtask
   task automatic t_sleep;
      req(2'h2);
      chk("sleep", 8'h02, {6'h00, mode_o});
      chk("sleep clk", 8'h00, clk_en_o);
      chk("timer", 8'h01, {7'h00, sleep_timer_run_o});
      wake(3'h1);
      wait_active;
      chk("resume", SR[7:0], n[7:0]);
      $display("test sleep done");
   endtask
   task automatic t_hib;
      core_reg_off_i = 1'b1;
      step(1);
      chk("regs off", 8'h01, {4'h0, regs_o});
      core_reg_off_i = 1'b0;
      req(2'h3);
      chk("hib stop", 8'h01, {7'h00, all_clk_stop_o});
      chk("hib regs", 8'h01, {4'h0, regs_o});
      chk("hib retain", 8'h01, {7'h00, retain_o});
      wake(3'h7);
      step(2);
      chk("hib stays", 8'h03, {6'h00, mode_o});
      pin_wake_i = 1'b1;
      step(1);
      pin_wake_i = 1'b0;
      wait_active;
      // Two synchroniser stages sit ahead of the settle count
      chk("hib wait", 8'(HR + 2), n[7:0]);
      $display("test hibernate done");
   endtask
   task automatic t_reset2;
      req(2'h2);
      reset_n_i = 1'b0;
      step(2);
      reset_n_i = 1'b1;
      step(1);
      chk("mode after reset", 8'h00, {6'h00, mode_o});
      chk("cpu after reset", 8'h5b, clk_en_o);
      $display("test second reset done");
   endtask
   initial begin
      step(6);
      reset_n_i = 1'b1;
      t_boot;
      t_active;
      t_alt;
      t_sleep;
      t_hib;
      t_reset2;
      close_out;
   end
endmodule // test_pmc_ctrl
